// File: bts_pkg.sv
package bts_pkg;

   // -------------------------------------------------------------
   // backplane timing
   // -------------------------------------------------------------
   localparam int CYCLE_NS        = 200;   // backplane cycle period
   localparam int STATE_NS        = 50;    // nominal time state length
   localparam int CLK_PERIOD_NS   = 25;    // core clock period
   // least time state length in core cycles, rounded up
   localparam int STATE_MIN_CYC   = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATES_PER_CYC  = 4;

   // -------------------------------------------------------------
   // primary clock line codes {hi, lo} seen in each time state
   // -------------------------------------------------------------
   localparam logic [1:0] CODE_T0 = 2'h2;
   localparam logic [1:0] CODE_T1 = 2'h3;
   localparam logic [1:0] CODE_T2 = 2'h1;
   localparam logic [1:0] CODE_T3 = 2'h0;

   // -------------------------------------------------------------
   // widths, defaults and reset values
   // -------------------------------------------------------------
   localparam int          DATA_W          = 32;
   localparam int          TIMEOUT_CYCLES  = 16;  // backplane cycles
   localparam int          TIMEOUT_W       = 16;
   localparam logic [31:0] DATA_RST        = 32'h0000_0000;

   // time state encoding presented on the status output
   typedef enum logic [1:0] {
      BTS_T0 = 2'h0,
      BTS_T1 = 2'h1,
      BTS_T2 = 2'h2,
      BTS_T3 = 2'h3
   } bts_state_t;

endpackage : bts_pkg

// File: bts_sync.sv
`timescale 1ns/10ps
`default_nettype none

// -------------------------------------------------------------
// two flip-flop level synchroniser
// -------------------------------------------------------------
module bts_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // first stage feeds only the second stage
   always_comb begin
      meta_d = i_async;
      sync_d = meta_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;

endmodule : bts_sync

`default_nettype wire

// File: bts_pulse_xfer.sv
`timescale 1ns/10ps
`default_nettype none

// -------------------------------------------------------------
// one-cycle event crossing by toggle
// -------------------------------------------------------------
module bts_pulse_xfer (
   input  wire logic i_src_clk,
   input  wire logic i_dst_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pulse,
   output logic      o_pulse
);

   logic tog_q;
   logic tog_d;
   logic tog_sync;
   logic seen_q;
   logic seen_d;

   // source side flips a level once per event
   always_comb begin
      tog_d = tog_q ^ i_pulse;
   end

   always_ff @(posedge i_src_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tog_q <= 1'b0;
      end else begin
         tog_q <= tog_d;
      end
   end

   bts_sync #(.WIDTH(1)) u_sync (
      .i_clk   (i_dst_clk),
      .i_rst_n (i_rst_n),
      .i_async (tog_q),
      .o_sync  (tog_sync)
   );

   // destination compares the settled level with its last copy
   always_comb begin
      seen_d = tog_sync;
   end

   always_ff @(posedge i_dst_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
      end
   end

   assign o_pulse = tog_sync ^ seen_q;

endmodule : bts_pulse_xfer

`default_nettype wire

// File: bts_core.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - time states come from two primary lines
// - four states T0..T3 per cycle, T0 first
// - at least T0 and T2 are generated
// - drive enable before T0, data from T0
// - latch open T2, closed T3, use latched
// - any state may stretch indefinitely, stays correct
// - timeout counted in backplane cycles
// - an external strobe while a send is pending sets data-late, a receive into an unread word sets overrun
module bts_core #(
   parameter int                DATA_W         = bts_pkg::DATA_W,
   parameter int                TIMEOUT_W      = bts_pkg::TIMEOUT_W,
   parameter logic [TIMEOUT_W-1:0] TIMEOUT_CYCLES = TIMEOUT_W'(bts_pkg::TIMEOUT_CYCLES)
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_link_clk,
   // backplane clock lines
   input  wire logic              i_time_base_clock_hi,
   input  wire logic              i_time_base_clock_lo,
   input  wire logic              i_phased_clock_a_hi,
   input  wire logic              i_phased_clock_a_lo,
   input  wire logic              i_phased_clock_b_hi,
   input  wire logic              i_phased_clock_b_lo,
   // backplane information path
   input  wire logic [DATA_W-1:0] i_bp_data,
   input  wire logic              i_bp_valid,
   output logic      [DATA_W-1:0] o_bp_data,
   output logic                   o_bp_drive_en,
   // link domain status
   output logic      [1:0]        o_time_state,
   output logic                   o_phase_fault,
   // core side transmit
   input  wire logic              i_tx_valid,
   input  wire logic [DATA_W-1:0] i_tx_data,
   output logic                   o_tx_ready,
   // core side receive
   output logic                   o_rx_valid,
   output logic      [DATA_W-1:0] o_rx_data,
   input  wire logic              i_rx_ready,
   // timeout
   input  wire logic              i_timeout_arm,
   output logic                   o_timeout,
   // external device timing and error flags
   input  wire logic              i_ext_strobe,
   input  wire logic              i_err_clear,
   output logic                   o_data_late,
   output logic                   o_overrun
);

   // -------------------------------------------------------------
   // link domain: pin synchronisers
   // -------------------------------------------------------------
   localparam int PIN_W = DATA_W + 7;

   logic [PIN_W-1:0]  pin_sync;
   logic [1:0]        prim_code;
   logic [3:0]        phased;
   logic [DATA_W-1:0] bp_data_s;
   logic              bp_valid_s;

   bts_sync #(.WIDTH(PIN_W)) u_pin_sync (
      .i_clk   (i_link_clk),
      .i_rst_n (i_rst_n),
      .i_async ({i_time_base_clock_hi, i_time_base_clock_lo,
                 i_phased_clock_a_hi, i_phased_clock_a_lo,
                 i_phased_clock_b_hi, i_phased_clock_b_lo,
                 i_bp_valid, i_bp_data}),
      .o_sync  (pin_sync)
   );

   // split the settled pins
   assign prim_code  = pin_sync[PIN_W-1 -: 2];
   assign phased     = pin_sync[PIN_W-3 -: 4];
   assign bp_valid_s = pin_sync[DATA_W];
   assign bp_data_s  = pin_sync[DATA_W-1:0];

   // -------------------------------------------------------------
   // link domain: time state generator
   // -------------------------------------------------------------
   bts_pkg::bts_state_t state_q;
   bts_pkg::bts_state_t state_d;
   bts_pkg::bts_state_t next_st;
   logic [1:0]          next_code;
   logic                adv;

   // only the next state's code may advance; a stretched state just waits
   always_comb begin
      case (state_q)
         bts_pkg::BTS_T0: begin
            next_st   = bts_pkg::BTS_T1;
            next_code = bts_pkg::CODE_T1;
         end
         bts_pkg::BTS_T1: begin
            next_st   = bts_pkg::BTS_T2;
            next_code = bts_pkg::CODE_T2;
         end
         bts_pkg::BTS_T2: begin
            next_st   = bts_pkg::BTS_T3;
            next_code = bts_pkg::CODE_T3;
         end
         bts_pkg::BTS_T3: begin
            next_st   = bts_pkg::BTS_T0;
            next_code = bts_pkg::CODE_T0;
         end
         default: begin
            next_st   = bts_pkg::BTS_T0;
            next_code = bts_pkg::CODE_T0;
         end
      endcase
      adv     = (prim_code == next_code);
      state_d = adv ? next_st : state_q;
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= bts_pkg::BTS_T0;
      end else begin
         state_q <= state_d;
      end
   end

   // transition strobes used by transmit, receive and timeout
   logic enter_t0;
   logic enter_t1;
   logic enter_t3;
   assign enter_t0 = adv && (state_q == bts_pkg::BTS_T3);
   assign enter_t1 = adv && (state_q == bts_pkg::BTS_T0);
   assign enter_t3 = adv && (state_q == bts_pkg::BTS_T2);

   // -------------------------------------------------------------
   // link domain: phased line check and status
   // -------------------------------------------------------------
   logic fault_q;
   logic fault_d;

   // each phased pair must be complementary, else skew is out of range
   always_comb begin
      fault_d = (phased[3] == phased[2]) || (phased[1] == phased[0]);
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   assign o_phase_fault = fault_q;
   assign o_time_state  = state_q;

   // -------------------------------------------------------------
   // link domain: transmit
   // -------------------------------------------------------------
   logic              tx_req_lnk;
   logic              tx_done_lnk;
   logic              tx_pend_q;
   logic              tx_pend_d;
   logic              drv_q;
   logic              drv_d;
   logic [DATA_W-1:0] out_q;
   logic [DATA_W-1:0] out_d;
   logic [DATA_W-1:0] tx_hold_q;

   // enable rises at entry to T3, data goes out at T0, both drop at T1
   always_comb begin
      tx_pend_d   = tx_pend_q;
      drv_d       = drv_q;
      out_d       = out_q;
      tx_done_lnk = 1'b0;
      if (tx_req_lnk) begin
         tx_pend_d = 1'b1;
      end
      if (enter_t3 && tx_pend_q) begin
         drv_d = 1'b1;
      end
      if (enter_t0 && drv_q) begin
         out_d = tx_hold_q;
      end
      if (enter_t1 && drv_q) begin
         drv_d       = 1'b0;
         out_d       = bts_pkg::DATA_RST[DATA_W-1:0];
         tx_pend_d   = 1'b0;
         tx_done_lnk = 1'b1;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_pend_q <= 1'b0;
         drv_q     <= 1'b0;
         out_q     <= '0;
      end else begin
         tx_pend_q <= tx_pend_d;
         drv_q     <= drv_d;
         out_q     <= out_d;
      end
   end

   assign o_bp_drive_en = drv_q;
   assign o_bp_data     = out_q;

   // -------------------------------------------------------------
   // link domain: receive latch
   // -------------------------------------------------------------
   logic [DATA_W-1:0] lat_q;
   logic [DATA_W-1:0] lat_d;
   logic              lat_v_q;
   logic              lat_v_d;
   logic              rx_lnk;

   // transparent through T2, frozen from T3; only the frozen copy is used
   always_comb begin
      lat_d   = lat_q;
      lat_v_d = lat_v_q;
      if (state_q == bts_pkg::BTS_T2 && !adv) begin
         lat_d   = bp_data_s;
         lat_v_d = bp_valid_s;
      end
      rx_lnk = enter_t3 && lat_v_q;
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lat_q   <= '0;
         lat_v_q <= 1'b0;
      end else begin
         lat_q   <= lat_d;
         lat_v_q <= lat_v_d;
      end
   end

   // -------------------------------------------------------------
   // link domain: cycle-counted timeout
   // -------------------------------------------------------------
   logic                 arm_lnk;
   logic [TIMEOUT_W-1:0] to_cnt_q;
   logic [TIMEOUT_W-1:0] to_cnt_d;
   logic                 to_q;
   logic                 to_d;

   // counts backplane cycles, so stretched states lengthen the limit
   always_comb begin
      to_cnt_d = to_cnt_q;
      to_d     = to_q;
      if (!arm_lnk) begin
         to_cnt_d = '0;
         to_d     = 1'b0;
      end else if (enter_t0 && !to_q) begin
         to_cnt_d = to_cnt_q + TIMEOUT_W'(1);
         to_d     = (to_cnt_d >= TIMEOUT_CYCLES);
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         to_cnt_q <= '0;
         to_q     <= 1'b0;
      end else begin
         to_cnt_q <= to_cnt_d;
         to_q     <= to_d;
      end
   end

   // -------------------------------------------------------------
   // domain crossings
   // -------------------------------------------------------------
   logic tx_req_core;
   logic tx_done_core;
   logic rx_core;
   logic to_core;
   logic ext_s;

   bts_pulse_xfer u_tx_req (
      .i_src_clk (i_clk),
      .i_dst_clk (i_link_clk),
      .i_rst_n   (i_rst_n),
      .i_pulse   (tx_req_core),
      .o_pulse   (tx_req_lnk)
   );

   bts_pulse_xfer u_tx_done (
      .i_src_clk (i_link_clk),
      .i_dst_clk (i_clk),
      .i_rst_n   (i_rst_n),
      .i_pulse   (tx_done_lnk),
      .o_pulse   (tx_done_core)
   );

   bts_pulse_xfer u_rx (
      .i_src_clk (i_link_clk),
      .i_dst_clk (i_clk),
      .i_rst_n   (i_rst_n),
      .i_pulse   (rx_lnk),
      .o_pulse   (rx_core)
   );

   bts_sync #(.WIDTH(1)) u_arm_sync (
      .i_clk   (i_link_clk),
      .i_rst_n (i_rst_n),
      .i_async (i_timeout_arm),
      .o_sync  (arm_lnk)
   );

   bts_sync #(.WIDTH(2)) u_core_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async ({to_q, i_ext_strobe}),
      .o_sync  ({to_core, ext_s})
   );

   // -------------------------------------------------------------
   // core domain: transmit hand-off, receive, error flags
   // -------------------------------------------------------------
   logic              busy_q;
   logic              busy_d;
   logic [DATA_W-1:0] hold_d;
   logic              rxv_q;
   logic              rxv_d;
   logic [DATA_W-1:0] rxd_q;
   logic [DATA_W-1:0] rxd_d;
   logic              ext_prev_q;
   logic              late_q;
   logic              late_d;
   logic              ovr_q;
   logic              ovr_d;
   logic              ext_rise;

   // held word stays stable until the link reports it sent
   always_comb begin
      tx_req_core = i_tx_valid && !busy_q;
      busy_d      = busy_q;
      hold_d      = tx_hold_q;
      if (tx_done_core) begin
         busy_d = 1'b0;
      end
      if (tx_req_core) begin
         busy_d = 1'b1;
         hold_d = i_tx_data;
      end
      rxv_d = rxv_q && !i_rx_ready;
      rxd_d = rxd_q;
      if (rx_core && !(rxv_q && !i_rx_ready)) begin
         rxv_d = 1'b1;
         rxd_d = lat_q;
      end
      ext_rise = ext_s && !ext_prev_q;
      // a new event wins over a clear in the same cycle
      late_d = (late_q && !i_err_clear) || (ext_rise && busy_q);
      ovr_d  = (ovr_q && !i_err_clear) || (rx_core && rxv_q && !i_rx_ready);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q     <= 1'b0;
         tx_hold_q  <= '0;
         rxv_q      <= 1'b0;
         rxd_q      <= '0;
         ext_prev_q <= 1'b0;
         late_q     <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         busy_q     <= busy_d;
         tx_hold_q  <= hold_d;
         rxv_q      <= rxv_d;
         rxd_q      <= rxd_d;
         ext_prev_q <= ext_s;
         late_q     <= late_d;
         ovr_q      <= ovr_d;
      end
   end

   assign o_tx_ready  = !busy_q;
   assign o_rx_valid  = rxv_q;
   assign o_rx_data   = rxd_q;
   assign o_timeout   = to_core;
   assign o_data_late = late_q;
   assign o_overrun   = ovr_q;

endmodule : bts_core

`default_nettype wire

// File: bts_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------
// port checker of the core
// -----------------------------
module bts_core_sva #(
   parameter int DATA_W = 32
) (
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic              i_link_clk,
   input wire logic              i_time_base_clock_hi,
   input wire logic              i_time_base_clock_lo,
   input wire logic              i_tx_valid,
   input wire logic              i_rx_ready,
   input wire logic              i_timeout_arm,
   input wire logic              i_err_clear,
   input wire logic [DATA_W-1:0] o_bp_data,
   input wire logic              o_bp_drive_en,
   input wire logic [1:0]        o_time_state,
   input wire logic              o_tx_ready,
   input wire logic              o_rx_valid,
   input wire logic [DATA_W-1:0] o_rx_data,
   input wire logic              o_timeout,
   input wire logic              o_data_late
);
   // pin code of each time state, T0 lowest
   localparam logic [7:0] CODES = {bts_pkg::CODE_T3, bts_pkg::CODE_T2,
                                   bts_pkg::CODE_T1, bts_pkg::CODE_T0};

   a_state_step: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      $changed(o_time_state) |-> o_time_state == $past(o_time_state) + 2'h1)
      else $error("time state out of order");
   a_state_code: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      $changed(o_time_state) |->
      $past({i_time_base_clock_hi, i_time_base_clock_lo}, 2) == CODES[2*o_time_state +: 2])
      else $error("time state without its line code");
   a_drive_rise: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      $rose(o_bp_drive_en) |-> o_time_state == 2'h3) else $error("drive enable late");
   a_drive_off: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      o_time_state == 2'h1 || o_time_state == 2'h2 |-> !o_bp_drive_en)
      else $error("drive enable outside window");
   a_data_t0: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      o_bp_data != '0 |-> o_bp_drive_en && o_time_state == 2'h0)
      else $error("word outside T0");
   a_tx_take: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_tx_valid && o_tx_ready |=> !o_tx_ready) else $error("ready after take");
   a_rx_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
      else $error("receive word lost");
   a_late_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_data_late && !i_err_clear |=> o_data_late) else $error("late flag lost");
   a_timeout_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_timeout_arm [*8] |-> !o_timeout) else $error("timeout without arm");

   c_send: cover property (@(posedge i_link_clk) $rose(o_bp_drive_en));
   c_recv: cover property (@(posedge i_clk) $rose(o_rx_valid));
   c_tout: cover property (@(posedge i_clk) $rose(o_timeout));
endmodule : bts_core_sva

bind bts_core bts_core_sva #(.DATA_W(DATA_W)) u_sva (.*);
`default_nettype wire

// File: bts_bp_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------
// backplane far end
// -----------------------------
module bts_bp_model (
   input  wire logic        i_link_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_hold,
   input  wire logic        i_phase_bad,
   input  wire logic        i_wvalid,
   input  wire logic [31:0] i_word,
   output logic             o_time_base_clock_hi,
   output logic             o_time_base_clock_lo,
   output logic             o_phased_clock_a_hi,
   output logic             o_phased_clock_a_lo,
   output logic             o_phased_clock_b_hi,
   output logic             o_phased_clock_b_lo,
   output logic             o_valid,
   output logic [31:0]      o_data
);
   logic [1:0]  st_q;
   logic [7:0]  cnt_q;
   logic        send_q;
   logic [31:0] junk_q;
   // steps T0..T3, each state lasts i_hold link cycles
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q   <= 2'h0;
         cnt_q  <= 8'h00;
         send_q <= 1'b0;
         junk_q <= 32'h5a5a_c3c3;
      end else begin
         junk_q <= ~junk_q;                 // released lines never hold a stale word
         cnt_q  <= cnt_q + 8'h01;
         if (cnt_q + 8'h01 >= i_hold) begin  // any state may be stretched
            cnt_q  <= 8'h00;
            st_q   <= st_q + 2'h1;           // one period of four states
            // far end launches when leaving its own state one, which is backplane T1
            send_q <= (st_q == 2'h1) ? i_wvalid : (st_q == 2'h3) ? 1'b0 : send_q;
         end
      end
   end
   // line codes of the common time base, phased pairs complementary while i_phase_bad is low
   assign o_time_base_clock_hi = ~st_q[1];
   assign o_time_base_clock_lo = st_q[1] ^ st_q[0];
   assign o_phased_clock_a_hi  = o_time_base_clock_hi;
   assign o_phased_clock_a_lo  = i_phase_bad ? o_time_base_clock_hi : ~o_time_base_clock_hi;
   assign o_phased_clock_b_hi  = o_time_base_clock_lo;
   assign o_phased_clock_b_lo  = ~o_time_base_clock_lo;
   // word stands through T2 and T3 only
   assign o_valid = send_q;
   assign o_data  = send_q ? i_word : junk_q;
endmodule : bts_bp_model
`default_nettype wire

// File: backplane_time_state_sync_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin logic [31:0] got, want; got = (a); want = (e); n_checks++; \
   if (got !== want) begin error_cnt++; \
   $display("wrong value at %0t ns: got %h exp %h", $time, got, want); end end
// -----------------------------
// bench of the time state core
// -----------------------------
module backplane_time_state_sync_test;
   logic        i_clk, i_rst_n, i_link_clk, i_tx_valid, i_rx_ready, i_timeout_arm;
   logic        i_ext_strobe, i_err_clear, i_bp_valid, o_bp_drive_en, o_phase_fault;
   logic        o_tx_ready, o_rx_valid, o_timeout, o_data_late, o_overrun, pbad, wvalid;
   logic        i_time_base_clock_hi, i_time_base_clock_lo, i_phased_clock_a_hi;
   logic        i_phased_clock_a_lo, i_phased_clock_b_hi, i_phased_clock_b_lo;
   logic [1:0]  o_time_state, ts_p;
   logic [7:0]  hold;
   logic [31:0] i_tx_data, i_bp_data, o_bp_data, o_rx_data, word;
   logic [31:0] txq[$], rxq[$];
   int          error_cnt, n_checks, cyc;

   bts_core #(.TIMEOUT_CYCLES(16'h0004)) u_dut (.*);
   bts_bp_model u_far (
      .i_link_clk           (i_link_clk),
      .i_rst_n              (i_rst_n),
      .i_hold               (hold),
      .i_phase_bad          (pbad),
      .i_wvalid             (wvalid),
      .i_word               (word),
      .o_time_base_clock_hi (i_time_base_clock_hi),
      .o_time_base_clock_lo (i_time_base_clock_lo),
      .o_phased_clock_a_hi  (i_phased_clock_a_hi),
      .o_phased_clock_a_lo  (i_phased_clock_a_lo),
      .o_phased_clock_b_hi  (i_phased_clock_b_hi),
      .o_phased_clock_b_lo  (i_phased_clock_b_lo),
      .o_valid              (i_bp_valid),
      .o_data               (i_bp_data)
   );

   // core clock and free link clock of unrelated phase
   always #12.5 i_clk = ~i_clk;
   initial begin
      i_link_clk = 1'b0;
      #3.7;
      forever #6 i_link_clk = ~i_link_clk;
   end

   // word on the backplane at each T0 entry
   always @(posedge i_link_clk) begin
      #1;
      if (o_time_state === 2'h0 && ts_p === 2'h3 && o_bp_drive_en === 1'b1) begin
         if (txq.size() > 0) `CHK(o_bp_data, txq.pop_front())
         else `CHK(o_bp_drive_en, 1'b0)
      end
      ts_p = o_time_state;
   end
   // received words handed to the core
   always @(posedge i_clk) begin
      if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
         if (rxq.size() > 0) `CHK(o_rx_data, rxq.pop_front())
         else `CHK(o_rx_valid, 1'b0)
      end
   end
   // watchdog against a hang
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic clk_n(input int n);
      repeat (n) @(posedge i_clk);
   endtask : clk_n
   // waits for the core to enter time state s
   task automatic wait_st(input logic [1:0] s);
      logic [1:0] p;
      p = o_time_state;
      @(posedge i_link_clk);
      #1;
      while (!(o_time_state === s && p !== s)) begin
         p = o_time_state;
         @(posedge i_link_clk);
         #1;
      end
   endtask : wait_st
   task automatic send(input logic [31:0] d);
      @(posedge i_clk);
      while (o_tx_ready !== 1'b1) @(posedge i_clk);
      i_tx_valid <= 1'b1;
      i_tx_data  <= d;
      txq.push_back(d);
      @(posedge i_clk);
      i_tx_valid <= 1'b0;
   endtask : send
   // one word offered by the far end in the next period
   task automatic recv(input logic [31:0] d, input logic keep);
      wait_st(2'h3);
      @(posedge i_clk);
      word   <= d;
      wvalid <= 1'b1;
      if (keep) rxq.push_back(d);
      wait_st(2'h3);
      @(posedge i_clk);
      wvalid <= 1'b0;
   endtask : recv
   task automatic drain;
      while (txq.size() > 0 || o_tx_ready !== 1'b1) @(posedge i_clk);
   endtask : drain
   task automatic strobe_or_clear(input logic clr);
      if (clr) i_err_clear <= 1'b1;
      else i_ext_strobe <= 1'b1;
      clk_n(3);
      i_err_clear  <= 1'b0;
      i_ext_strobe <= 1'b0;
      clk_n(6);
   endtask : strobe_or_clear
   task automatic done(input string t);
      $display("test %s finished, mismatches so far %0d", t, error_cnt);
   endtask : done
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      i_clk         = 1'b0;
      i_rst_n       = 1'b0;
      i_tx_valid    = 1'b0;
      i_tx_data     = 32'h0;
      i_rx_ready    = 1'b1;
      i_timeout_arm = 1'b0;
      i_ext_strobe  = 1'b0;
      i_err_clear   = 1'b0;
      pbad          = 1'b0;
      wvalid        = 1'b0;
      word          = 32'h0;
      hold          = 8'h04;
      void'($urandom(94188));
      clk_n(2);
      `CHK(o_tx_ready, 1'b1)
      `CHK(o_time_state, 2'h0)
      i_rst_n <= 1'b1;
      clk_n(4);
      done("reset");
      send($urandom());
      send($urandom());
      recv($urandom(), 1'b1);
      recv($urandom(), 1'b1);
      drain;
      clk_n(8);
      `CHK(rxq.size(), 0)
      done("back to back");
      i_rx_ready <= 1'b0;
      recv($urandom(), 1'b1);
      recv($urandom(), 1'b0);
      clk_n(8);
      `CHK(o_overrun, 1'b1)
      i_rx_ready <= 1'b1;
      strobe_or_clear(1'b1);
      `CHK(o_overrun, 1'b0)
      done("overrun");
      hold <= 8'h1e;
      strobe_or_clear(1'b0);
      `CHK(o_data_late, 1'b0)
      send($urandom());
      strobe_or_clear(1'b0);
      `CHK(o_data_late, 1'b1)
      recv($urandom(), 1'b1);
      drain;
      strobe_or_clear(1'b1);
      `CHK(o_data_late, 1'b0)
      `CHK(rxq.size(), 0)
      done("stretch and late");
      hold <= 8'h14;
      i_timeout_arm <= 1'b1;
      repeat (3) wait_st(2'h0);
      clk_n(4);
      `CHK(o_timeout, 1'b0)
      repeat (2) wait_st(2'h0);
      clk_n(4);
      `CHK(o_timeout, 1'b1)
      i_timeout_arm <= 1'b0;
      clk_n(8);
      `CHK(o_timeout, 1'b0)
      done("timeout");
      pbad <= 1'b1;
      clk_n(4);
      `CHK(o_phase_fault, 1'b1)
      wait_st(2'h2);
      @(posedge i_clk);
      pbad <= 1'b0;
      clk_n(4);
      `CHK(o_phase_fault, 1'b0)
      `CHK(txq.size(), 0)
      done("phase");
      give_verdict();
   end
endmodule : backplane_time_state_sync_test
`default_nettype wire
